//--- ast_defines.svh
// Constants for the acquisition sequence timing block
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH

// System clock rate in Hz (100 MHz)
`define AST_CLK_HZ 32'h05F5E100
// Fastest internal timebase in Hz (1 MHz)
`define AST_TB_BASE_HZ 32'h000F4240
// Clock cycles per fastest timebase tick, derived from the two rates
`define AST_TB_PRE_CYC (`AST_CLK_HZ / `AST_TB_BASE_HZ)
// Width of the prescaler counter
`define AST_TB_PRE_W 7
// Ratio between neighbouring internal timebases
`define AST_TB_DECADE 4'hA
// Number of decade stages below the fastest timebase
`define AST_TB_STAGES 4

// Bit positions of the pin inputs in the synchroniser vector
`define AST_IN_TRIG_EXT 0
`define AST_IN_TRIG_START 1
`define AST_IN_CONV 2
`define AST_IN_GATE 3
`define AST_IN_TB 4
`define AST_IN_NUM 5

// Scan sequence limits
`define AST_SCAN_MAX 5'h10
`define AST_ENTRY_W 4

`endif

//--- ast_pkg.sv
// Types shared by the acquisition sequence timing modules
package ast_pkg;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE      = 3'h1,
        ST_RUN       = 3'h2,
        ST_SCAN_WAIT = 3'h4
    } ast_state_t;

    // Source of the starting trigger
    typedef enum logic [1:0] {
        TRIG_EXT_PIN   = 2'h0,
        TRIG_START_PIN = 2'h1,
        TRIG_SOFT      = 2'h2
    } ast_trig_src_t;

    // Timebase for the sample-interval counter
    typedef enum logic [2:0] {
        TB_1MHZ   = 3'h0,
        TB_100KHZ = 3'h1,
        TB_10KHZ  = 3'h2,
        TB_1KHZ   = 3'h3,
        TB_100HZ  = 3'h4,
        TB_EXT    = 3'h5
    } ast_tb_sel_t;

endpackage : ast_pkg

//--- ast_evt_if.sv
// Synchronised pin levels and edges passed between the timing modules
`timescale 1ns/1ps
interface ast_evt_if #(parameter int W = 5);
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface : ast_evt_if

//--- ast_sync.sv
// Two-stage synchroniser with edge detection for the pin inputs
`timescale 1ns/1ps
module ast_sync #(
    parameter int W = 5
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Raw pins
    input wire logic [W-1:0] i_async,
    // Synchronised levels and edges
    ast_evt_if.src evt
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;

    // Width must cover at least one pin
    generate
        if (W < 1) begin : g_bad_w
            $error("ast_sync: W must be at least 1");
        end
    endgenerate

    // Only the second stage and its delayed copy feed any logic
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // One pulse per pin edge
    assign evt.lvl = sync_ff;
    assign evt.rise = sync_ff & ~prev_ff; // R20
    assign evt.fall = ~sync_ff & prev_ff; // R20

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_fall_single: assert property (|evt.fall |=> ~|(evt.fall & $past(evt.fall))) // R20
        else $error("pin edge produced two falling events");
endmodule : ast_sync

//--- ast_timebase.sv
// Internal decade timebase and external timebase selection
`timescale 1ns/1ps
`include "ast_defines.svh"
module ast_timebase (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Rate selection
    input wire ast_pkg::ast_tb_sel_t i_sel,
    // Synchronised pins
    ast_evt_if.dst evt,
    // One-cycle tick at the chosen rate
    output logic o_tick
);
    import ast_pkg::*;

    localparam logic [`AST_TB_PRE_W-1:0] PRE_LAST = `AST_TB_PRE_W'(`AST_TB_PRE_CYC - 1);
    localparam logic [3:0] DEC_LAST = `AST_TB_DECADE - 4'h1;

    logic [`AST_TB_PRE_W-1:0] pre_ff;
    logic [3:0] dec_ff [`AST_TB_STAGES];
    logic [`AST_TB_STAGES:0] stage;
    logic nxt_tick;
    logic tick_ff;

    // Prescaler must fit its counter
    generate
        if (`AST_TB_PRE_CYC > (1 << `AST_TB_PRE_W) || `AST_TB_PRE_CYC < 1) begin : g_bad_pre
            $error("ast_timebase: prescaler count does not fit");
        end
    endgenerate

    // Stage k carries the tick of the k-th slower decade
    always_comb begin
        stage[0] = (pre_ff == PRE_LAST);
        for (int k = 0; k < `AST_TB_STAGES; k++) begin
            stage[k+1] = stage[k] && (dec_ff[k] == DEC_LAST);
        end
    end

    // Prescaler from the system clock down to the fastest rate
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= stage[0] ? '0 : pre_ff + 1'b1;
        end
    end

    // Cascaded decade dividers, free running so rates stay aligned
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int k = 0; k < `AST_TB_STAGES; k++) begin
                dec_ff[k] <= 4'h0;
            end
        end else begin
            for (int k = 0; k < `AST_TB_STAGES; k++) begin
                if (stage[k]) begin
                    dec_ff[k] <= (dec_ff[k] == DEC_LAST) ? 4'h0 : dec_ff[k] + 4'h1;
                end
            end
        end
    end

    // Rate selection
    always_comb begin
        case (i_sel)
            TB_1MHZ: nxt_tick = stage[0]; // R09
            TB_100KHZ: nxt_tick = stage[1]; // R09
            TB_10KHZ: nxt_tick = stage[2]; // R09
            TB_1KHZ: nxt_tick = stage[3]; // R09
            TB_100HZ: nxt_tick = stage[4]; // R09
            TB_EXT: nxt_tick = evt.rise[`AST_IN_TB]; // R10
            default: nxt_tick = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
        end
    end

    assign o_tick = tick_ff;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_tick_fast_spacing: assert property ((i_sel == TB_1MHZ && o_tick) |=> !o_tick [*8]) // R09
        else $error("1 MHz timebase ticked too soon");
    a_tick_ext_source: assert property ((i_sel == TB_EXT && $past(i_sel) == TB_EXT && o_tick)
        |-> $past(evt.rise[`AST_IN_TB])) // R10
        else $error("external timebase tick without input edge");
endmodule : ast_timebase

//--- ast_acq_timing.sv
// Acquisition sequence timing: trigger, conversion pulses, sample and scan control
//
// Behaviour
// R01: A sequence starts only on a trigger edge, never on a steady level.
// R02: Trigger comes from the trigger pin, start pin or software, by configuration.
// R03: While running, exactly one conversion pulse per sample interval.
// R04: Conversion pulses from internal interval counter or external convert pin.
// R05: External converts before trigger cannot be blocked and still advance the mux.
// R06: Internal conversions are counted by the sample counter.
// R07: At the requested sample count timing stops, no more conversion pulses.
// R08: Gate low suspends acquisition timing; high resumes it.
// R09: Internal timebase selectable as 1 MHz, 100 kHz, 10 kHz, 1 kHz or 100 Hz.
// R10: Interval counter may be clocked from an external timebase input.
// R11: Host keeps 12-bit channel-switch settling between 10 and 80 us by gain.
// R12: Host keeps 16-bit settling per accuracy target, 30 us upward.
// R13: Host keeps 12-bit single-channel rate under the grade maximum.
// R14: Host keeps 16-bit single-channel rate at 23.8 or 55.6 kS/s max.
// R15: Host limits 12-bit scan rate to 25 or 12.5 kS/s at high gain.
// R16: Host limits 16-bit scan rate by gain and accuracy target.
// R17: After the last scan entry the sequence restarts at the first entry.
// R18: Interval scanning waits out the scan interval before the next pass.
// R19: Scan sequence length is 1 to 16 entries.
// R20: Trigger, convert and gate pins are synchronised; one event per edge.
`timescale 1ns/1ps
`include "ast_defines.svh"
module ast_acq_timing #(
    parameter int DIV_W = 16,
    parameter int CNT_W = 24
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // External pins
    input wire logic I_EXTERNAL_TRIGGER_IN_N,
    input wire logic I_START_TRIGGER_IN_N,
    input wire logic I_EXTERNAL_CONVERT_IN_N,
    input wire logic I_EXTERNAL_GATE_IN,
    input wire logic I_EXTERNAL_TIMEBASE_IN,
    // Software commands
    input wire logic I_SOFT_START,
    input wire logic I_ABORT,
    // Configuration
    input wire ast_pkg::ast_trig_src_t I_TRIG_SRC,
    input wire logic I_CONV_EXT,
    input wire ast_pkg::ast_tb_sel_t I_TB_SEL,
    input wire logic I_GATE_EN,
    input wire logic [DIV_W-1:0] I_SAMPLE_DIV,
    input wire logic [CNT_W-1:0] I_SAMPLE_COUNT,
    input wire logic I_SCAN_EN,
    input wire logic [4:0] I_SCAN_LEN,
    input wire logic I_SCAN_IVL_EN,
    input wire logic [DIV_W-1:0] I_SCAN_DIV,
    // Converter and multiplexer
    output logic O_CONVERT,
    output logic [`AST_ENTRY_W-1:0] O_MUX_ENTRY,
    // Status
    output logic O_BUSY,
    output logic O_DONE,
    output logic O_GATED,
    output logic [CNT_W-1:0] O_SAMPLES
);
    import ast_pkg::*;

    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // Parameter sanity
    generate
        if (DIV_W < 2 || CNT_W < 1) begin : g_bad_param
            $error("ast_acq_timing: DIV_W must be >= 2 and CNT_W >= 1");
        end
    endgenerate

    // Reload value for an interval of d ticks; zero acts as one tick
    function automatic logic [DIV_W-1:0] ivl_load(input logic [DIV_W-1:0] d);
        ivl_load = (d == '0) ? '0 : d - 1'b1;
    endfunction : ivl_load

    // True when e is the last entry of a sequence of len entries, clamped to 1..16
    function automatic logic is_last(input logic [`AST_ENTRY_W-1:0] e, input logic [4:0] len);
        logic [4:0] eff;
        eff = (len == 5'h00) ? 5'h01 : ((len > `AST_SCAN_MAX) ? `AST_SCAN_MAX : len);
        is_last = ({1'b0, e} == (eff - 5'h01));
    endfunction : is_last

    ast_evt_if #(.W(`AST_IN_NUM)) evt_bus ();

    ast_state_t state_ff;
    ast_state_t nxt_state;
    logic soft_prev_ff;
    logic soft_edge;
    logic trig_edge;
    logic gate_ok;
    logic tb_tick;
    logic adv;
    logic stop;
    logic conv_int;
    logic conv_ext;
    logic conv_any;
    logic ivl_scan;
    logic start;
    logic pass_start;
    logic [DIV_W-1:0] iv_ff;
    logic [DIV_W-1:0] sc_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] tgt_ff;
    logic [`AST_ENTRY_W-1:0] entry_ff;
    logic convert_ff;
    logic done_ff;
    logic gated_ff;

    // Pins in bit order: timebase, gate, convert, start trigger, trigger
    ast_sync #(.W(`AST_IN_NUM)) u_sync (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_async({I_EXTERNAL_TIMEBASE_IN, I_EXTERNAL_GATE_IN, I_EXTERNAL_CONVERT_IN_N,
            I_START_TRIGGER_IN_N, I_EXTERNAL_TRIGGER_IN_N}),
        .evt(evt_bus.src)
    );

    ast_timebase u_tb (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_sel(I_TB_SEL),
        .evt(evt_bus.dst),
        .o_tick(tb_tick)
    );

    // Software start is edge detected so a held command starts only once
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            soft_prev_ff <= 1'b0;
        end else begin
            soft_prev_ff <= I_SOFT_START;
        end
    end

    // Trigger source selection; pins are active low, so falling edges count
    always_comb begin
        soft_edge = I_SOFT_START & ~soft_prev_ff; // R01
        case (I_TRIG_SRC)
            TRIG_EXT_PIN: trig_edge = evt_bus.fall[`AST_IN_TRIG_EXT]; // R02
            TRIG_START_PIN: trig_edge = evt_bus.fall[`AST_IN_TRIG_START]; // R02
            TRIG_SOFT: trig_edge = soft_edge; // R02
            default: trig_edge = 1'b0;
        endcase
    end

    // Timing enables and conversion sources
    assign gate_ok = ~I_GATE_EN | evt_bus.lvl[`AST_IN_GATE]; // R08
    assign adv = tb_tick & gate_ok; // R08
    assign stop = (cnt_ff >= tgt_ff); // R07
    assign conv_int = (state_ff == ST_RUN) && !I_CONV_EXT && adv && (iv_ff == '0) && !stop; // R03
    // External converts cannot be masked, even before the trigger
    assign conv_ext = I_CONV_EXT & evt_bus.fall[`AST_IN_CONV]; // R05
    assign conv_any = conv_int | conv_ext; // R04
    assign ivl_scan = I_SCAN_EN & I_SCAN_IVL_EN;
    assign start = (state_ff == ST_IDLE) && trig_edge && !I_ABORT; // R01
    assign pass_start = (state_ff == ST_SCAN_WAIT) && (nxt_state == ST_RUN);

    // Sequencer; abort wins over everything
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (trig_edge) begin
                    nxt_state = ST_RUN; // R01
                end
            end
            ST_RUN: begin
                if (!I_CONV_EXT && stop) begin
                    nxt_state = ST_IDLE; // R07
                end else if (conv_int && ivl_scan && is_last(entry_ff, I_SCAN_LEN)
                        && ((cnt_ff + CNT_ONE) < tgt_ff)) begin
                    nxt_state = ST_SCAN_WAIT; // R18
                end
            end
            ST_SCAN_WAIT: begin
                if (adv && sc_ff == '0) begin
                    nxt_state = ST_RUN; // R18
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (I_ABORT) begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Sample-interval counter; holds while gated
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            iv_ff <= '0;
        end else if (start || pass_start) begin
            iv_ff <= ivl_load(I_SAMPLE_DIV);
        end else if (state_ff == ST_RUN && adv) begin
            iv_ff <= (iv_ff == '0) ? ivl_load(I_SAMPLE_DIV) : iv_ff - 1'b1; // R03
        end
    end

    // Scan-interval counter runs through the pass and the wait
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            sc_ff <= '0;
        end else if (start || pass_start) begin
            sc_ff <= ivl_load(I_SCAN_DIV); // R18
        end else if (state_ff != ST_IDLE && adv && sc_ff != '0) begin
            sc_ff <= sc_ff - 1'b1; // R18
        end
    end

    // Sample counter and the target latched at the trigger
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            cnt_ff <= '0;
            tgt_ff <= '0;
        end else if (start) begin
            cnt_ff <= '0;
            tgt_ff <= I_SAMPLE_COUNT;
        end else if (conv_int) begin
            cnt_ff <= cnt_ff + CNT_ONE; // R06
        end
    end

    // Mux entry; not cleared at an externally clocked start, so early converts shift it
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            entry_ff <= '0;
        end else if (!I_SCAN_EN || (start && !I_CONV_EXT)) begin
            entry_ff <= '0;
        end else if (conv_any) begin
            entry_ff <= is_last(entry_ff, I_SCAN_LEN) ? '0 : entry_ff + 1'b1; // R17 R19 R05
        end
    end

    // Registered outputs
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            convert_ff <= 1'b0;
            done_ff <= 1'b0;
            gated_ff <= 1'b0;
        end else begin
            convert_ff <= conv_any; // R03 R04
            done_ff <= (state_ff == ST_RUN) && (nxt_state == ST_IDLE) && !I_ABORT; // R07
            gated_ff <= (state_ff != ST_IDLE) && !gate_ok;
        end
    end

    assign O_CONVERT = convert_ff;
    assign O_MUX_ENTRY = entry_ff;
    assign O_BUSY = (state_ff != ST_IDLE);
    assign O_DONE = done_ff;
    assign O_GATED = gated_ff;
    assign O_SAMPLES = cnt_ff;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    sequence s_last_internal;
        conv_int && ivl_scan && is_last(entry_ff, I_SCAN_LEN) && ((cnt_ff + CNT_ONE) < tgt_ff)
            && !I_ABORT;
    endsequence

    sequence s_wait_then_resume;
        (state_ff == ST_SCAN_WAIT && convert_ff) ##1 (state_ff == ST_SCAN_WAIT);
    endsequence

    sequence s_finish;
        (state_ff == ST_IDLE && done_ff) ##1 !done_ff;
    endsequence

    a_no_level_start: assert property ((state_ff == ST_IDLE && !trig_edge) |=> state_ff == ST_IDLE) // R01
        else $error("sequence started without a trigger edge");
    a_trig_starts_run: assert property (start |=> state_ff == ST_RUN && cnt_ff == '0) // R02
        else $error("trigger edge did not start a sequence");
    a_convert_single: assert property (O_CONVERT |=> !O_CONVERT) // R03
        else $error("conversion pulse longer than one cycle");
    a_conv_int_cause: assert property ((O_CONVERT && !$past(I_CONV_EXT))
        |-> $past(state_ff == ST_RUN && tb_tick && gate_ok && iv_ff == '0)) // R04
        else $error("internal conversion without an interval expiry");
    a_count_step: assert property (conv_int |=> cnt_ff == $past(cnt_ff) + CNT_ONE) // R06
        else $error("sample counter missed a conversion");
    a_stop_at_count: assert property ((state_ff == ST_RUN && !I_CONV_EXT && stop && !I_ABORT)
        |-> !conv_int ##1 s_finish) // R07
        else $error("timing did not stop at the sample count");
    a_gate_holds: assert property ((state_ff != ST_IDLE && !gate_ok && !I_ABORT)
        |=> iv_ff == $past(iv_ff) && sc_ff == $past(sc_ff) && !($past(conv_int))) // R08
        else $error("timing advanced while gated");
    a_entry_wrap: assert property ((conv_any && I_SCAN_EN && is_last(entry_ff, I_SCAN_LEN)
        && !start) |=> entry_ff == '0) // R17
        else $error("scan did not restart at the first entry");
    a_entry_step: assert property ((conv_any && I_SCAN_EN && !is_last(entry_ff, I_SCAN_LEN)
        && !start) |=> entry_ff == $past(entry_ff) + 1'b1) // R19
        else $error("scan entry did not advance by one");
    a_scan_wait: assert property ((s_last_internal ##1 (sc_ff != '0 && !I_ABORT))
        |-> s_wait_then_resume or (state_ff == ST_SCAN_WAIT ##1 state_ff == ST_IDLE)) // R18
        else $error("next pass began before the scan interval ended");
endmodule : ast_acq_timing

//--- ast_far_model.sv
// Behavioural far side: trigger, convert, gate and timebase sources
`timescale 1ns/1ps
module ast_far_model #(
    parameter int CONV_GAP = 20000
) (
    // Clock
    input wire logic i_clk,
    // Pins towards the block
    output logic o_trig_n,
    output logic o_start_n,
    output logic o_conv_n,
    output logic o_gate,
    output logic o_tb
);
    // Idle levels: strobes high, gate open, timebase still
    initial begin
        o_trig_n = 1'b1;
        o_start_n = 1'b1;
        o_conv_n = 1'b1;
        o_gate = 1'b1;
        o_tb = 1'b0;
    end

    // Low pulse on one strobe pin; converts keep a settling gap after
    task automatic strobe(input int pin, input int lo);
        @(negedge i_clk);
        case (pin)
            0: o_trig_n = 1'b0;
            1: o_start_n = 1'b0;
            default: o_conv_n = 1'b0;
        endcase
        repeat (lo) @(negedge i_clk);
        o_trig_n = 1'b1;
        o_start_n = 1'b1;
        o_conv_n = 1'b1;
        repeat (2) @(negedge i_clk);
        // Gap well above the settling and rate limits at moderate gain
        if (pin == 2) repeat (CONV_GAP) @(negedge i_clk);
    endtask : strobe

    // Gate level, given time to pass the synchroniser
    task automatic set_gate(input logic v);
        @(negedge i_clk);
        o_gate = v;
        repeat (4) @(negedge i_clk);
    endtask : set_gate

    // External timebase pulses; the line stands still between them
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge i_clk);
            o_tb = 1'b1;
            repeat (3) @(negedge i_clk);
            o_tb = 1'b0;
            repeat (3) @(negedge i_clk);
        end
    endtask : tick
endmodule : ast_far_model

//--- tb_ast_acq_timing.sv
// Self-checking bench for the acquisition sequence timing block
`timescale 1ns/1ps
module tb_ast_acq_timing;
    import ast_pkg::*;
    logic I_CLK = 1'b0;
    logic I_RESET = 1'b1;
    logic I_SOFT_START = 1'b0;
    logic I_ABORT = 1'b0;
    ast_trig_src_t I_TRIG_SRC = TRIG_SOFT;
    logic I_CONV_EXT = 1'b0;
    ast_tb_sel_t I_TB_SEL = TB_1MHZ;
    logic I_GATE_EN = 1'b0;
    logic [15:0] I_SAMPLE_DIV = 16'h0001;
    logic [23:0] I_SAMPLE_COUNT = 24'h000002;
    logic I_SCAN_EN = 1'b0;
    logic [4:0] I_SCAN_LEN = 5'h01;
    logic I_SCAN_IVL_EN = 1'b0;
    logic [15:0] I_SCAN_DIV = 16'h0000;
    logic trig_n, start_n, conv_n, gate, tbase;
    logic O_CONVERT, O_BUSY, O_DONE, O_GATED;
    logic [3:0] O_MUX_ENTRY;
    logic [23:0] O_SAMPLES;
    int bad_count = 0;
    int n_tests = 0;
    int seed = 95;
    int cyc = 0, last = 0, gap = 0, conv_cnt = 0, done_cnt = 0;

    // 100 MHz clock
    always #5 I_CLK = ~I_CLK;

    ast_far_model far_u (.i_clk(I_CLK), .o_trig_n(trig_n), .o_start_n(start_n),
        .o_conv_n(conv_n), .o_gate(gate), .o_tb(tbase));

    ast_acq_timing dut_u (.I_CLK(I_CLK), .I_RESET(I_RESET),
        .I_EXTERNAL_TRIGGER_IN_N(trig_n), .I_START_TRIGGER_IN_N(start_n),
        .I_EXTERNAL_CONVERT_IN_N(conv_n), .I_EXTERNAL_GATE_IN(gate),
        .I_EXTERNAL_TIMEBASE_IN(tbase), .I_SOFT_START(I_SOFT_START), .I_ABORT(I_ABORT),
        .I_TRIG_SRC(I_TRIG_SRC), .I_CONV_EXT(I_CONV_EXT), .I_TB_SEL(I_TB_SEL),
        .I_GATE_EN(I_GATE_EN), .I_SAMPLE_DIV(I_SAMPLE_DIV), .I_SAMPLE_COUNT(I_SAMPLE_COUNT),
        .I_SCAN_EN(I_SCAN_EN), .I_SCAN_LEN(I_SCAN_LEN), .I_SCAN_IVL_EN(I_SCAN_IVL_EN),
        .I_SCAN_DIV(I_SCAN_DIV), .O_CONVERT(O_CONVERT), .O_MUX_ENTRY(O_MUX_ENTRY),
        .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_GATED(O_GATED), .O_SAMPLES(O_SAMPLES));

    // One-cycle pulses counted in the cycle they stand; gap is the last spacing
    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (O_CONVERT === 1'b1) begin
            conv_cnt <= conv_cnt + 1;
            gap <= cyc - last;
            last <= cyc;
        end
        if (O_DONE === 1'b1) done_cnt <= done_cnt + 1;
    end

    // Clock cycles per internal timebase tick
    function automatic int exp_period(input int r);
        int p;
        p = 100;
        repeat (r) p = p * 10;
        return p;
    endfunction : exp_period

    // Entry shown after cnt conversions over len entries
    function automatic logic [3:0] exp_entry(input int cnt, input int len);
        return 4'(cnt % len);
    endfunction : exp_entry

    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_num(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: value %0d, expected %0d", $time, got, exp);
        end
    endtask : cmp_num

    task automatic go_soft;
        @(negedge I_CLK);
        I_SOFT_START = 1'b1;
        @(negedge I_CLK);
        I_SOFT_START = 1'b0;
    endtask : go_soft

    // Bounded wait for the sequence to end; two more edges let the done pulse be counted
    task automatic wait_idle(input int lim);
        for (int i = 0; i < lim && O_BUSY !== 1'b0; i++) @(negedge I_CLK);
        repeat (2) @(negedge I_CLK);
    endtask : wait_idle

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        int r, k, cnt, len, dv, c0, d0;
        logic [3:0] e0;
        repeat (3) @(negedge I_CLK);
        I_RESET = 1'b0;
        repeat (4) @(negedge I_CLK);
        for (r = 0; r < 3; r++) begin
            I_TB_SEL = ast_tb_sel_t'(r);
            c0 = conv_cnt;
            d0 = done_cnt;
            go_soft();
            cmp_bit(O_BUSY, 1'b1);
            wait_idle(3 * exp_period(r) + 50);
            cmp_num(24'(gap), 24'(exp_period(r)));
            cmp_num(24'(conv_cnt - c0), 24'h000002);
            cmp_num(24'(done_cnt - d0), 24'h000001);
            cmp_num(O_SAMPLES, 24'h000002);
        end
        $display("test timebase rates done");
        // Scan wrap: longest list, zero count, random mixes, then a 5-tick scan interval
        I_SCAN_EN = 1'b1;
        I_TB_SEL = TB_1MHZ;
        for (k = 0; k < 7; k++) begin
            len = (k == 0) ? 16 : (k == 6) ? 2 : 1 + {$random(seed)} % 5;
            cnt = (k == 0) ? 17 : (k == 1) ? 0 : (k == 6) ? 3 : 1 + {$random(seed)} % 8;
            dv = (k == 0 || k == 6) ? 1 : 1 + {$random(seed)} % 3;
            I_SCAN_IVL_EN = (k == 6);
            I_SCAN_DIV = (k == 6) ? 16'h0005 : 16'h0000;
            I_SCAN_LEN = 5'(len);
            I_SAMPLE_COUNT = 24'(cnt);
            I_SAMPLE_DIV = 16'(dv);
            c0 = conv_cnt;
            go_soft();
            wait_idle(cnt * dv * 100 + 800);
            cmp_num(24'(conv_cnt - c0), 24'(cnt));
            cmp_num(O_SAMPLES, 24'(cnt));
            cmp_num(24'(O_MUX_ENTRY), 24'(exp_entry(cnt, len)));
            // After the pass, the wait fills the 5-tick interval: 4 ticks to the next pass
            if (cnt > 1) cmp_num(24'(gap), 24'((k == 6) ? 400 : dv * 100));
        end
        I_SCAN_IVL_EN = 1'b0;
        $display("test scan wrap done");
        // A held start level gives one sequence only
        I_SAMPLE_DIV = 16'h0001;
        I_SAMPLE_COUNT = 24'h000001;
        c0 = conv_cnt;
        @(negedge I_CLK);
        I_SOFT_START = 1'b1;
        repeat (300) @(negedge I_CLK);
        cmp_bit(O_BUSY, 1'b0);
        cmp_num(24'(conv_cnt - c0), 24'h000001);
        I_SOFT_START = 1'b0;
        // Each pin source: the other pin is ignored, a long low starts once
        for (r = 0; r < 2; r++) begin
            I_TRIG_SRC = ast_trig_src_t'(r);
            far_u.strobe(1 - r, 4);
            cmp_bit(O_BUSY, 1'b0);
            c0 = conv_cnt;
            far_u.strobe(r, 400);
            cmp_num(24'(conv_cnt - c0), 24'h000001);
            cmp_bit(O_BUSY, 1'b0);
        end
        I_TRIG_SRC = TRIG_SOFT;
        $display("test trigger sources done");
        // Gate low holds the interval counter
        I_GATE_EN = 1'b1;
        I_SAMPLE_COUNT = 24'h000002;
        far_u.set_gate(1'b0);
        c0 = conv_cnt;
        go_soft();
        repeat (500) @(negedge I_CLK);
        cmp_bit(O_GATED, 1'b1);
        cmp_num(24'(conv_cnt - c0), 24'h000000);
        far_u.set_gate(1'b1);
        wait_idle(400);
        cmp_num(24'(conv_cnt - c0), 24'h000002);
        cmp_bit(O_GATED, 1'b0);
        $display("test gate done");
        // External timebase: three ticks make one interval
        I_GATE_EN = 1'b0;
        I_TB_SEL = TB_EXT;
        I_SAMPLE_DIV = 16'h0003;
        I_SAMPLE_COUNT = 24'h000001;
        c0 = conv_cnt;
        go_soft();
        far_u.tick(2);
        cmp_num(24'(conv_cnt - c0), 24'h000000);
        far_u.tick(1);
        cmp_num(24'(conv_cnt - c0), 24'h000001);
        wait_idle(20);
        cmp_bit(O_BUSY, 1'b0);
        $display("test external timebase done");
        // External converts, idle first: they still move the entry
        I_CONV_EXT = 1'b1;
        I_SCAN_LEN = 5'h10;
        e0 = O_MUX_ENTRY;
        c0 = conv_cnt;
        far_u.strobe(2, 50);
        cmp_num(24'(conv_cnt - c0), 24'h000001);
        cmp_num(24'(O_MUX_ENTRY), 24'(4'(e0 + 4'h1)));
        go_soft();
        far_u.strobe(2, 50);
        cmp_num(24'(conv_cnt - c0), 24'h000002);
        cmp_num(O_SAMPLES, 24'h000000);
        cmp_bit(O_BUSY, 1'b1);
        @(negedge I_CLK);
        I_ABORT = 1'b1;
        @(negedge I_CLK);
        I_ABORT = 1'b0;
        $display("test external convert done");
        tally_and_finish();
    end

    // Watchdog well beyond the expected run, still under 100k cycles
    initial begin
        #950000;
        bad_count++;
        $display("ERROR at %0t: run did not finish", $time);
        tally_and_finish();
    end
endmodule : tb_ast_acq_timing
